// file: rtl/apfs_pkg.sv
// Package with register map, field positions and reset values of the pin mux.
package apfs_pkg;
  localparam logic [31:0] APFS_FUNC_OFFSET = 32'h0000_0010;
  localparam logic [31:0] APFS_DIR_OFFSET = 32'h0000_0014;
  localparam logic [31:0] APFS_GPIO_OUT_OFFSET = 32'h0000_0018;
  localparam logic [31:0] APFS_GPIO_IN_OFFSET = 32'h0000_001c;
  localparam int APFS_RX_FS_BIT = 31;
  localparam int APFS_RX_HCLK_BIT = 30;
  localparam int APFS_RX_BCLK_BIT = 29;
  localparam int APFS_TX_FS_BIT = 28;
  localparam int APFS_TX_HCLK_BIT = 27;
  localparam int APFS_TX_BCLK_BIT = 26;
  localparam int APFS_MUTE_BIT = 25;
  localparam int APFS_CTRL_LSB = 25;
  localparam int APFS_NUM_PINS = 23;
  localparam int APFS_DATA_PINS = 16;
  localparam logic [31:0] APFS_FUNC_RESET = 32'h0000_0000;
  localparam logic [31:0] APFS_DIR_RESET = 32'h0000_0000;
  localparam logic [31:0] APFS_GPIO_RESET = 32'h0000_0000;
  localparam logic [1:0] APFS_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] APFS_HSIZE_WORD = 3'h2;
endpackage : apfs_pkg

// file: rtl/apfs_pin_cell.sv
// One pad cell choosing serial port or GPIO control of a single pin.
`timescale 1ns/1ps
`default_nettype none
module apfs_pin_cell (
  input wire logic func_sel_in, // 1 selects GPIO
  input wire logic dir_in, // 1 drives the pin
  input wire logic port_out_in, // Serial port output level
  input wire logic gpio_out_in, // GPIO output level
  input wire logic pin_sync_in, // Synchronised pin level
  output logic pad_out, // Pad output level
  output logic pad_oe_out, // Pad output enable
  output logic port_in_out, // Level seen by serial port
  output logic gpio_in_out // Level seen by GPIO
);
  // The serial port sees zero while the pin is handed to GPIO.
  assign pad_out = func_sel_in ? gpio_out_in : port_out_in; // RULE14
  assign pad_oe_out = dir_in; // RULE13
  assign port_in_out = func_sel_in ? 1'b0 : pin_sync_in; // RULE14
  assign gpio_in_out = pin_sync_in;
endmodule : apfs_pin_cell
`default_nettype wire

// file: rtl/apfs_top.sv
// Audio port pin function select with AHB-Lite registers and pin muxing.
// Operation
// RULE1 - Bit 31 routes rx frame sync pin: 0 serial port, 1 GPIO.
// RULE2 - Bit 30 routes rx high clock pin: 0 serial port, 1 GPIO.
// RULE3 - Bit 29 routes rx bit clock pin: 0 serial port, 1 GPIO.
// RULE4 - Bit 28 routes tx frame sync pin: 0 serial port, 1 GPIO.
// RULE5 - Bit 27 routes tx high clock pin: 0 serial port, 1 GPIO.
// RULE6 - Bit 26 routes tx bit clock pin: 0 serial port, 1 GPIO.
// RULE7 - Bit 25 routes mute output pin: 0 serial port, 1 GPIO.
// RULE8 - Bit n selects function of data pin n for pins 0 to 7.
// RULE9 - Bits 15-8 exist only with sixteen data pins, else reserved.
// RULE10 - Bits 24-16 read zero and ignore writes.
// RULE11 - Software writes only zero to reserved bits.
// RULE12 - Reset clears every function select bit to serial port use.
// RULE13 - A separate direction bit sets output when 1, input when 0.
// RULE14 - GPIO selection disconnects the pin from serial port logic.
`timescale 1ns/1ps
`default_nettype none
module apfs_top #(
  parameter bit WIDE_DATA = 1'b1 // Sixteen data pins when set
) (
  input wire logic MCLK_IN, // 100 MHz clock
  input wire logic RST_N_IN, // Async reset, active low
  input wire logic HSEL_IN, // AHB slave select
  input wire logic [31:0] HADDR_IN, // AHB address
  input wire logic [1:0] HTRANS_IN, // AHB transfer type
  input wire logic HWRITE_IN, // AHB write
  input wire logic [2:0] HSIZE_IN, // AHB size
  input wire logic [31:0] HWDATA_IN, // AHB write data
  input wire logic HREADY_IN, // AHB bus ready
  output logic [31:0] HRDATA_OUT, // AHB read data
  output logic HREADYOUT_OUT, // AHB slave ready
  output logic HRESP_OUT, // AHB response, always OKAY
  input wire logic [22:0] PORT_OUT_IN, // Serial port levels per pin
  input wire logic [22:0] PIN_IN, // Pad levels from pins
  output logic [22:0] PIN_OUT, // Pad drive levels
  output logic [22:0] PIN_OE_OUT, // Pad output enables
  output logic [22:0] PORT_IN_OUT, // Pin levels to serial port
  output logic [31:0] FUNC_SEL_OUT // Function select register
);
  // Pin vector order: 15..0 data pins, 22..16 rx frame sync down to mute.
  logic [31:0] func_q;
  logic [31:0] dir_q;
  logic [31:0] gpio_out_q;
  logic [22:0] pin_meta_q;
  logic [22:0] pin_sync_q;
  logic [22:0] gpio_in_w;
  logic [22:0] port_in_w;
  logic [22:0] pad_w;
  logic [22:0] oe_w;
  logic [22:0] sel_v;
  logic [22:0] dir_v;
  logic [22:0] gout_v;
  logic [31:0] impl_mask;
  logic [31:0] gpio_in_word;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [31:0] addr_q;
  logic accept;

  // Implemented bits: control pins always, high data pins only if wide.
  assign impl_mask = {7'h7f, 9'h000, {8{WIDE_DATA}}, 8'hff}; // RULE9 RULE10

  assign accept = HSEL_IN && HREADY_IN && HTRANS_IN == apfs_pkg::APFS_HTRANS_NONSEQ
    && HSIZE_IN == apfs_pkg::APFS_HSIZE_WORD;

  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 32'h0000_0000;
    end
    else if (HREADY_IN)
    begin
      wr_pend_q <= accept && HWRITE_IN;
      rd_pend_q <= accept && !HWRITE_IN;
      addr_q <= HADDR_IN;
    end
  end

  // Writes land in the data phase; unimplemented bits are never stored.
  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      func_q <= apfs_pkg::APFS_FUNC_RESET; // RULE12
      dir_q <= apfs_pkg::APFS_DIR_RESET;
      gpio_out_q <= apfs_pkg::APFS_GPIO_RESET;
    end
    else if (wr_pend_q)
    begin
      if (addr_q == apfs_pkg::APFS_FUNC_OFFSET)
      begin
        func_q <= HWDATA_IN & impl_mask; // RULE10 RULE11
      end
      if (addr_q == apfs_pkg::APFS_DIR_OFFSET)
      begin
        dir_q <= HWDATA_IN & impl_mask; // RULE13
      end
      if (addr_q == apfs_pkg::APFS_GPIO_OUT_OFFSET)
      begin
        gpio_out_q <= HWDATA_IN & impl_mask;
      end
    end
  end

  // Read data and answer registered; zero-wait, always OKAY.
  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      HRDATA_OUT <= 32'h0000_0000;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= 1'b0;
    end
    else
    begin
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= 1'b0;
      if (HREADY_IN && accept && !HWRITE_IN)
      begin
        unique case (HADDR_IN)
          apfs_pkg::APFS_FUNC_OFFSET: HRDATA_OUT <= func_q; // RULE10
          apfs_pkg::APFS_DIR_OFFSET: HRDATA_OUT <= dir_q;
          apfs_pkg::APFS_GPIO_OUT_OFFSET: HRDATA_OUT <= gpio_out_q;
          apfs_pkg::APFS_GPIO_IN_OFFSET: HRDATA_OUT <= gpio_in_word;
          default: HRDATA_OUT <= 32'h0000_0000;
        endcase
      end
    end
  end

  // There is no bypass of a write to the same register in the read's address phase:
  // a back-to-back read issued in the write's data phase returns the value held
  // before the write; a read one cycle later sees the stored value.

  assign sel_v = {func_q[31:25], func_q[15:0]}; // RULE1 RULE2 RULE3 RULE4 RULE5 RULE6 RULE7 RULE8
  assign dir_v = {dir_q[31:25], dir_q[15:0]};
  assign gout_v = {gpio_out_q[31:25], gpio_out_q[15:0]};
  assign gpio_in_word = {gpio_in_w[22:16], 9'h000, gpio_in_w[15:0]} & impl_mask;

  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      pin_meta_q <= 23'h000000;
      pin_sync_q <= 23'h000000;
    end
    else
    begin
      pin_meta_q <= PIN_IN;
      pin_sync_q <= pin_meta_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < apfs_pkg::APFS_NUM_PINS; gi++)
    begin : g_pin
      apfs_pin_cell u_cell (
        .func_sel_in(sel_v[gi]),
        .dir_in(dir_v[gi]),
        .port_out_in(PORT_OUT_IN[gi]),
        .gpio_out_in(gout_v[gi]),
        .pin_sync_in(pin_sync_q[gi]),
        .pad_out(pad_w[gi]),
        .pad_oe_out(oe_w[gi]),
        .port_in_out(port_in_w[gi]),
        .gpio_in_out(gpio_in_w[gi])
      );
    end
  endgenerate

  // Outputs are re-registered so every top port comes from a flip-flop.
  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      PIN_OUT <= 23'h000000;
      PIN_OE_OUT <= 23'h000000;
      PORT_IN_OUT <= 23'h000000;
      FUNC_SEL_OUT <= apfs_pkg::APFS_FUNC_RESET;
    end
    else
    begin
      PIN_OUT <= pad_w; // RULE14
      PIN_OE_OUT <= oe_w; // RULE13
      PORT_IN_OUT <= port_in_w; // RULE14
      FUNC_SEL_OUT <= func_q;
    end
  end
endmodule : apfs_top
`default_nettype wire

// file: tb/apfs_checker.sv
// Assertion checker for the audio port pin function select.
`timescale 1ns/1ps
`default_nettype none
module apfs_checker #(
  parameter bit WIDE_DATA = 1'b1 // Sixteen data pins when set
) (
  input wire logic MCLK_IN, // Clock
  input wire logic RST_N_IN, // Reset, active low
  input wire logic [22:0] PORT_OUT_IN, // Serial port levels
  input wire logic [22:0] PIN_OUT, // Pad drive levels
  input wire logic [22:0] PIN_OE_OUT, // Pad enables
  input wire logic [22:0] PORT_IN_OUT, // Levels to serial port
  input wire logic [31:0] FUNC_SEL_OUT // Function select copy
);
  logic [22:0] s;
  logic [22:0] bad;
  assign s = {FUNC_SEL_OUT[31:25], FUNC_SEL_OUT[15:0]};
  assign bad = s & PORT_IN_OUT;
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!RST_N_IN);
  sequence q;
    $stable(FUNC_SEL_OUT)[*3];
  endsequence
  property p_rx_fs; q |-> !bad[22]; endproperty
  a_rx_fs: assert property (p_rx_fs) else $error("rx fs leak");
  property p_rx_hc; q |-> !bad[21]; endproperty
  a_rx_hc: assert property (p_rx_hc) else $error("rx hclk leak");
  property p_rx_bc; q |-> !bad[20]; endproperty
  a_rx_bc: assert property (p_rx_bc) else $error("rx bclk leak");
  property p_tx_fs; q |-> !bad[19]; endproperty
  a_tx_fs: assert property (p_tx_fs) else $error("tx fs leak");
  property p_tx_hc; q |-> !bad[18]; endproperty
  a_tx_hc: assert property (p_tx_hc) else $error("tx hclk leak");
  property p_tx_bc; q |-> !bad[17]; endproperty
  a_tx_bc: assert property (p_tx_bc) else $error("tx bclk leak");
  property p_mute; q |-> !bad[16]; endproperty
  a_mute: assert property (p_mute) else $error("mute leak");
  property p_data; q |-> bad[15:0] == 16'h0; endproperty
  a_data: assert property (p_data) else $error("data leak");
  property p_narrow; WIDE_DATA || FUNC_SEL_OUT[15:8] == 8'h0; endproperty
  a_narrow: assert property (p_narrow) else $error("narrow bits");
  property p_rsv; FUNC_SEL_OUT[24:16] == 9'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved set");
  property p_rst; $rose(RST_N_IN) |-> FUNC_SEL_OUT == 32'h0; endproperty
  a_rst: assert property (p_rst) else $error("select not clear");
  property p_dir; $changed(FUNC_SEL_OUT) |-> $stable(PIN_OE_OUT); endproperty
  a_dir: assert property (p_dir) else $error("enable moved");
  property p_port;
    q ##0 $past(RST_N_IN) |-> ((PIN_OUT ^ $past(PORT_OUT_IN)) & ~s) == 23'h0;
  endproperty
  a_port: assert property (p_port) else $error("port drive lost");
endmodule : apfs_checker
bind apfs_top apfs_checker #(.WIDE_DATA(WIDE_DATA)) u_chk (
  .MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN), .PORT_OUT_IN(PORT_OUT_IN),
  .PIN_OUT(PIN_OUT), .PIN_OE_OUT(PIN_OE_OUT), .PORT_IN_OUT(PORT_IN_OUT),
  .FUNC_SEL_OUT(FUNC_SEL_OUT));
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking testbench for the audio port pin function select.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rst_n, hsel, hwrite, hrdy, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, fsel, rd;
  logic [22:0] pout, pin, pio, poe, pport;
  int miscompares, checks_done;
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  apfs_top dut (.MCLK_IN(clk), .RST_N_IN(rst_n), .HSEL_IN(hsel),
    .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
    .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hrdy),
    .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hrdy), .HRESP_OUT(hresp),
    .PORT_OUT_IN(pout), .PIN_IN(pin), .PIN_OUT(pio), .PIN_OE_OUT(poe),
    .PORT_IN_OUT(pport), .FUNC_SEL_OUT(fsel));
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task wait_rdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hrdy !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (hrdy !== 1'b1)
    begin
      miscompares++;
      tally_and_finish();
    end
  endtask : wait_rdy
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= apfs_pkg::APFS_HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= apfs_pkg::APFS_HSIZE_WORD;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    chk("response", 32'h0, {31'h0, hresp});
  endtask : xfer
  task t_pins;
    logic [22:0] m;
    for (int b = 0; b < 32; b++)
    begin
      if (b < 16 || b > 24)
      begin
        m = 23'h1 << (b > 24 ? b - 9 : b);
        xfer(1'b1, apfs_pkg::APFS_FUNC_OFFSET, 32'h1 << b);
        repeat (4) @(posedge clk);
        chk("pin out", {9'h0, ~m}, {9'h0, pio});
        chk("port in", {9'h0, ~m}, {9'h0, pport});
        chk("select copy", 32'h1 << b, fsel);
        xfer(1'b0, apfs_pkg::APFS_FUNC_OFFSET, 32'h0);
        chk("select", 32'h1 << b, rd);
      end
    end
    $display("test pins done");
  endtask : t_pins
  task t_regs;
    xfer(1'b0, apfs_pkg::APFS_FUNC_OFFSET, 32'h0);
    chk("reset select", 32'h0, rd);
    xfer(1'b1, apfs_pkg::APFS_FUNC_OFFSET, 32'hffff_ffff);
    xfer(1'b0, apfs_pkg::APFS_FUNC_OFFSET, 32'h0);
    chk("reserved", 32'hfe00_ffff, rd);
    xfer(1'b1, apfs_pkg::APFS_DIR_OFFSET, 32'hfe00_ffff);
    xfer(1'b1, apfs_pkg::APFS_FUNC_OFFSET, 32'h0);
    repeat (4) @(posedge clk);
    chk("enables", 32'h007f_ffff, {9'h0, poe});
    xfer(1'b0, 32'h0000_0040, 32'h0);
    chk("unmapped", 32'h0, rd);
    xfer(1'b0, apfs_pkg::APFS_GPIO_IN_OFFSET, 32'h0);
    chk("gpio in", 32'hfe00_ffff, rd);
    xfer(1'b1, apfs_pkg::APFS_GPIO_OUT_OFFSET, 32'hfe00_ffff);
    xfer(1'b1, apfs_pkg::APFS_FUNC_OFFSET, 32'hfe00_ffff);
    repeat (4) @(posedge clk);
    chk("gpio drive", 32'h007f_ffff, {9'h0, pio});
    chk("port cut", 32'h0, {9'h0, pport});
    xfer(1'b1, apfs_pkg::APFS_GPIO_OUT_OFFSET, 32'h0);
    xfer(1'b1, apfs_pkg::APFS_FUNC_OFFSET, 32'h0);
    $display("test registers done");
  endtask : t_regs
  initial
  begin
    rst_n = 1'b0;
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    pout = '1;
    pin = '1;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_pins();
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
